// *** supervision_pkg.sv ***
`default_nettype none
package supervision_pkg;

	// Register byte offsets on the APB slave
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] FLAGS_OFS  = 8'h08;
	localparam logic [7:0] CFG_OFS    = 8'h0C;

	// Control register fields
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_CLR_PRIM   = 3;
	localparam int CTRL_CLR_SEC    = 4;
	localparam int CTRL_PAR_INJECT = 5;

	// Reset values
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [7:0] CFG_RST  = 8'h00;

	// Operating modes touched by this block
	localparam logic [2:0] OP_MODE_0 = 3'h0;
	localparam logic [2:0] OP_MODE_3 = 3'h3;
	localparam logic [2:0] OP_MODE_4 = 3'h4;
	localparam logic [2:0] OP_MODE_5 = 3'h5;
	localparam logic [2:0] OP_MODE_6 = 3'h6;

	// Lifesign timing, clocked by the own oscillator
	localparam int CLK_MHZ         = 50;
	localparam int LS_PERIOD_US    = 10;
	localparam int LS_TIMEOUT_US   = 30;
	localparam int LS_PERIOD_CYC   = LS_PERIOD_US * CLK_MHZ;
	localparam int LS_TIMEOUT_CYC  = LS_TIMEOUT_US * CLK_MHZ;

	// Index of each pin in the synchronised input vector
	localparam int IX_EN       = 0;
	localparam int IX_LS       = 1;
	localparam int IX_BIAS     = 2;
	localparam int IX_PRIMARY_OSCILLATOR     = 3;
	localparam int IX_SEC_OSC  = 4;
	localparam int IX_SEC_HARD = 5;
	localparam int IX_SEC_MEM  = 6;
	localparam int IX_SEC_LOST = 7;
	localparam int PIN_W       = 8;

	// Status reported by the secondary chip across the link
	typedef struct packed {
		logic osc_fault;
		logic hard_fault;
		logic mem_err;
		logic ls_lost;
	} sec_status_s;

	// Notification pins toward the host
	typedef struct packed {
		logic fault_a_n;
		logic fault_b_n;
		logic reset_ready_n;
	} notify_s;

endpackage : supervision_pkg
`default_nettype wire

// *** enable_and_supervision.sv ***
`default_nettype none
// Operation
// RL1: Enable falling edge raises Class A event
// RL2: Enable valid only high; low means disabled
// RL3: Valid enable alone does not leave disabled
// RL4: Enable rising clears faults in modes 3,5
// RL5: Report enable pin level and validity
// RL6: Each chip sends and checks periodic lifesign
// RL7: Lifesign error: reset, mode 0, fault_b_n
// RL8: Lifesign error sets both comm-loss flags
// RL9: Secondary ready shows live link state
// RL10: Bias pin fault holds primary in reset
// RL11: Configuration parity checked continuously
// RL12: Primary memory error: reset, both lines, turn-off
// RL13: Secondary memory error: turn-off, lifesign loss
// RL14: Primary failures: reset flag, fault_b_n at end
// RL15: Secondary loss flag, PWM off during primary reset
// RL16: Secondary oscillator fault: fault_b_n, flag, not ready
// RL17: Secondary hard faults: fault_b_n, flag, not ready
// RL18: All notification outputs are active low
// RL19: Class A asserts fault_a_n only on 4-3, 6-5
// RL20: Fixed lifesign period and timeout counters
// RL21: Enable synchronised before edge detection
module enable_and_supervision (
	// Clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Pins and detectors
	input  wire logic                        enable_pin,
	input  wire logic                        lifesign_rx,
	input  wire logic                        bias_ref_fault,
	input  wire logic                        primary_osc_fail,
	input  wire supervision_pkg::sec_status_s sec_status,
	// Notifications and link
	output supervision_pkg::notify_s         notify,
	output logic                             lifesign_tx,
	output logic                             reset_event,
	output logic                             pwm_off,
	output logic                             disabled,
	output logic                             enable_pin_level,
	output logic                             enable_valid_status,
	output logic                             secondary_ready_status
);

	////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [supervision_pkg::PIN_W-1:0] sync1;
		logic [supervision_pkg::PIN_W-1:0] sync2;
		logic        en_prev;
		logic        ls_prev;
		logic [2:0]  op_mode;
		logic        fault_a;
		logic        fault_b;
		logic        in_reset;
		logic        link_up;
		logic        p_comm;
		logic        s_comm;
		logic        p_rst;
		logic        en_err;
		logic [7:0]  cfg;
		logic        cfg_par;
		logic        inject;
		logic [10:0] tx_cnt;
		logic [10:0] rx_cnt;
		logic        ls_tx;
		logic        ls_err;
		logic        pwm_off;
		logic [31:0] prdata;
	} state_s;

	localparam logic [10:0] TX_LAST = 11'(supervision_pkg::LS_PERIOD_CYC - 1);
	localparam logic [10:0] RX_LAST = 11'(supervision_pkg::LS_TIMEOUT_CYC - 1);

	state_s state_reg;
	state_s state_next;

	logic en_now;
	logic en_rise;
	logic en_fall;
	logic ls_edge;
	logic mem_err;
	logic prim_fault;
	logic sec_fault;
	logic rst_end;
	logic wr;
	logic sel_ctrl;
	logic sel_status;
	logic sel_flags;
	logic sel_cfg;
	logic mapped;
	logic clr_p;
	logic clr_s;
	logic set_a;
	logic set_b;
	logic mode_35;
	logic ls_timeout;

	////////////////////////////////////////////////////////////////
	// Decode of events from the registered state and the APB inputs

	always_comb begin
		en_now     = state_reg.sync2[supervision_pkg::IX_EN];
		en_rise    = en_now & ~state_reg.en_prev;                              // [RL21]
		en_fall    = ~en_now & state_reg.en_prev;                              // [RL21]
		ls_edge    = state_reg.sync2[supervision_pkg::IX_LS] & ~state_reg.ls_prev;
		// Any flipped bit or injected error breaks even parity
		mem_err    = ((^state_reg.cfg) ^ state_reg.cfg_par) | state_reg.inject; // [RL11]
		prim_fault = state_reg.sync2[supervision_pkg::IX_BIAS]                  // [RL10]
			| state_reg.sync2[supervision_pkg::IX_PRIMARY_OSCILLATOR] | mem_err;             // [RL14]
		sec_fault  = state_reg.sync2[supervision_pkg::IX_SEC_OSC]               // [RL16]
			| state_reg.sync2[supervision_pkg::IX_SEC_HARD]                    // [RL17]
			| state_reg.sync2[supervision_pkg::IX_SEC_MEM];                    // [RL13]
		rst_end    = state_reg.in_reset & ~prim_fault;
		ls_timeout = (state_reg.rx_cnt == RX_LAST) & ~ls_edge & ~state_reg.in_reset; // [RL20]
		mode_35    = (state_reg.op_mode == supervision_pkg::OP_MODE_3)
			| (state_reg.op_mode == supervision_pkg::OP_MODE_5);
		sel_ctrl   = paddr == supervision_pkg::CTRL_OFS;
		sel_status = paddr == supervision_pkg::STATUS_OFS;
		sel_flags  = paddr == supervision_pkg::FLAGS_OFS;
		sel_cfg    = paddr == supervision_pkg::CFG_OFS;
		mapped     = sel_ctrl | sel_status | sel_flags | sel_cfg;
		wr         = psel & penable & pwrite & mapped;
		clr_p      = wr & sel_ctrl & pwdata[supervision_pkg::CTRL_CLR_PRIM];
		clr_s      = wr & sel_ctrl & pwdata[supervision_pkg::CTRL_CLR_SEC];
		// Class A asserts only with the 4-3 or 6-5 mode transition
		set_a      = en_fall & ~prim_fault & ~state_reg.ls_err & ~sec_fault      // [RL19]
			& ((state_reg.op_mode == supervision_pkg::OP_MODE_4)
			| (state_reg.op_mode == supervision_pkg::OP_MODE_6));
		set_b      = state_reg.ls_err | rst_end | mem_err | sec_fault;        // [RL7] [RL12] [RL14]
	end

	////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		state_next = state_reg;

		// Two-stage synchroniser on every asynchronous pin
		state_next.sync1   = {sec_status.ls_lost, sec_status.mem_err, sec_status.hard_fault,
			sec_status.osc_fault, primary_osc_fail, bias_ref_fault, lifesign_rx, enable_pin}; // [RL21]
		state_next.sync2   = state_reg.sync1;
		state_next.en_prev = en_now;                                           // [RL5]
		state_next.ls_prev = state_reg.sync2[supervision_pkg::IX_LS];

		// Primary stays in reset while any own failure persists
		state_next.in_reset = prim_fault;                                      // [RL10] [RL12]

		// Lifesign transmit: silent during reset so the far side notices
		if (prim_fault) begin
			state_next.tx_cnt = '0;
			state_next.ls_tx  = 1'b0;
		end else if (state_reg.tx_cnt == TX_LAST) begin
			state_next.tx_cnt = '0;
			state_next.ls_tx  = 1'b1;                                          // [RL6]
		end else begin
			state_next.tx_cnt = state_reg.tx_cnt + 11'h001;
			state_next.ls_tx  = 1'b0;
		end

		// Lifesign receive window, restarted after each error
		state_next.ls_err = ls_timeout;                                        // [RL6]
		if (ls_edge | ls_timeout | state_reg.in_reset) begin
			state_next.rx_cnt = '0;
		end else begin
			state_next.rx_cnt = state_reg.rx_cnt + 11'h001;                    // [RL20]
		end

		// Live link state, apart from the sticky loss flags
		if (state_reg.ls_err | sec_fault) begin
			state_next.link_up = 1'b0;                                         // [RL9] [RL16] [RL17]
		end else if (ls_edge) begin
			state_next.link_up = 1'b1;                                         // [RL9]
		end

		// Sticky flags: a set in the clear cycle wins
		state_next.p_comm = (state_reg.p_comm & ~clr_p) | state_reg.ls_err | sec_fault; // [RL8] [RL16]
		state_next.s_comm = (state_reg.s_comm & ~clr_s) | state_reg.ls_err                // [RL8]
			| state_reg.sync2[supervision_pkg::IX_SEC_LOST];                               // [RL15]
		state_next.p_rst  = (state_reg.p_rst & ~clr_p) | rst_end;                          // [RL14]
		state_next.en_err = (state_reg.en_err & ~clr_p) | en_fall;                         // [RL1]

		// Operating mode: software write, Class A step, reset events
		if (wr & sel_ctrl & ~prim_fault) begin
			state_next.op_mode = pwdata[supervision_pkg::CTRL_MODE_LSB +: 3];
			state_next.inject  = pwdata[supervision_pkg::CTRL_PAR_INJECT];
		end else if (wr & sel_ctrl) begin
			state_next.inject  = pwdata[supervision_pkg::CTRL_PAR_INJECT];
		end
		if (set_a) begin
			state_next.op_mode = state_reg.op_mode - 3'h1;                     // [RL19]
		end
		if (prim_fault | state_reg.ls_err | sec_fault) begin
			state_next.op_mode = supervision_pkg::OP_MODE_0;                  // [RL7]
		end

		// Notifications: clear first so that a new event wins
		if (clr_p | (en_rise & mode_35)) begin
			state_next.fault_a = 1'b0;                                         // [RL4]
			state_next.fault_b = 1'b0;                                         // [RL4]
		end
		if (set_a) begin
			state_next.fault_a = 1'b1;                                         // [RL19]
		end
		if (set_b) begin
			state_next.fault_b = 1'b1;                                         // [RL7] [RL16] [RL17]
		end

		// Protected configuration; reset restores defaults with good parity
		if (prim_fault) begin
			state_next.cfg     = supervision_pkg::CFG_RST;
			state_next.cfg_par = ^supervision_pkg::CFG_RST;                    // [RL11]
		end else if (wr & sel_cfg) begin
			state_next.cfg     = pwdata[7:0];
			state_next.cfg_par = ^pwdata[7:0];                                 // [RL11]
		end

		// Output stage turn-off request on any failure or invalid enable
		state_next.pwm_off = prim_fault | sec_fault | state_reg.ls_err | ~en_now; // [RL12] [RL13] [RL15]

		// Read data captured in the setup phase
		if (psel & ~penable & ~pwrite) begin
			unique case (1'b1)
				sel_ctrl:   state_next.prdata = {26'h0, state_reg.inject, 2'h0, state_reg.op_mode};
				sel_status: state_next.prdata = {25'h0, state_reg.in_reset, disabled,
					secondary_ready_status, state_reg.op_mode[2:1],
					state_reg.en_prev, state_reg.en_prev};                         // [RL5]
				sel_flags:  state_next.prdata = {28'h0, state_reg.en_err, state_reg.p_rst,
					state_reg.s_comm, state_reg.p_comm};
				sel_cfg:    state_next.prdata = {24'h0, state_reg.cfg};
				default:    state_next.prdata = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg         <= '0;
			state_reg.op_mode <= supervision_pkg::MODE_RST;
			state_reg.cfg     <= supervision_pkg::CFG_RST;
			state_reg.cfg_par <= ^supervision_pkg::CFG_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs

	// Zero-wait slave; unmapped addresses error and read zero
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = state_reg.prdata;

	// Active-low notification lines; primary reset holds reset_ready_n low
	// One driver for the whole struct keeps the port a single variable
	assign notify = '{
		fault_a_n:     ~state_reg.fault_a,                                  // [RL18]
		fault_b_n:     ~state_reg.fault_b,                                  // [RL18]
		reset_ready_n: ~state_reg.in_reset                                  // [RL18] [RL10]
	};

	assign lifesign_tx            = state_reg.ls_tx;
	assign reset_event            = state_reg.ls_err;                       // [RL7]
	assign pwm_off                = state_reg.pwm_off;
	assign enable_pin_level       = state_reg.en_prev;                      // [RL5]
	assign enable_valid_status    = state_reg.en_prev;                      // [RL2] [RL5]
	assign secondary_ready_status = state_reg.link_up & ~sec_fault;         // [RL9]
	// High enable is necessary, never sufficient, to leave disabled
	assign disabled = ~state_reg.en_prev | state_reg.in_reset               // [RL2] [RL3]
		| (state_reg.op_mode == supervision_pkg::OP_MODE_0) | sec_fault;   // [RL3]

	////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_lifesign_lost;
		ls_timeout;
	endsequence

	sequence s_reset_applied;
		##1 (state_reg.op_mode == supervision_pkg::OP_MODE_0) && !notify.fault_b_n;
	endsequence

	a_fall_class_a: assert property (en_fall |=> state_reg.en_err) // [RL1]
		else $error("enable fall did not set its flag");
	a_low_en_disabled: assert property (!enable_valid_status |-> disabled) // [RL2]
		else $error("invalid enable not disabled");
	a_rise_clears_35: assert property (en_rise && mode_35 && !set_a && !set_b
		|=> notify.fault_a_n && notify.fault_b_n) // [RL4]
		else $error("enable rise did not clear notifications");
	a_tx_pulse_single: assert property ($rose(lifesign_tx) |=> !lifesign_tx [*8]) // [RL6]
		else $error("lifesign pulse too wide");
	a_lserr_reset: assert property (s_lifesign_lost |=> reset_event ##0 s_reset_applied) // [RL7]
		else $error("lifesign error did not reset");
	a_lserr_flags: assert property (reset_event |=> state_reg.p_comm && state_reg.s_comm) // [RL8]
		else $error("comm loss flags not set");
	a_bias_holds_reset: assert property ($rose(state_reg.sync2[supervision_pkg::IX_BIAS])
		|=> !notify.reset_ready_n && pwm_off) // [RL10]
		else $error("bias fault did not hold reset");
	a_mem_err_lines: assert property (mem_err |=> !notify.reset_ready_n && !notify.fault_b_n) // [RL12]
		else $error("memory error lines not asserted");
	a_reset_end_flag: assert property ($rose(notify.reset_ready_n)
		|-> state_reg.p_rst && !notify.fault_b_n) // [RL14]
		else $error("reset end not flagged");
	a_sec_fault_notify: assert property (sec_fault |-> !secondary_ready_status ##1
		(!notify.fault_b_n && state_reg.p_comm && pwm_off)) // [RL16]
		else $error("secondary fault not reported");
	a_class_a_4_to_3: assert property (set_a && state_reg.op_mode == supervision_pkg::OP_MODE_4
		|=> !notify.fault_a_n && state_reg.op_mode == supervision_pkg::OP_MODE_3) // [RL19]
		else $error("class A step from mode 4 wrong");
	// Silence while in reset is what lets the far side notice
	a_tx_quiet_reset: assert property (state_reg.in_reset |-> !lifesign_tx) // [RL10]
		else $error("lifesign sent during reset");
	// Far side loss report sets the sticky flag
	a_sec_lost_flag: assert property (state_reg.sync2[supervision_pkg::IX_SEC_LOST] // [RL15]
		|=> state_reg.s_comm)
		else $error("secondary loss flag not set");
	// Any secondary fault forces mode 0 and turn-off
	a_sec_hard_mode0: assert property (sec_fault // [RL17]
		|=> pwm_off && state_reg.op_mode == supervision_pkg::OP_MODE_0)
		else $error("secondary fault did not force mode 0");
	// A primary reset alone must leave the comm loss flag clear
	a_rst_no_comm: assert property (state_reg.in_reset && !sec_fault && !state_reg.ls_err // [RL14]
		&& !state_reg.p_comm |=> !state_reg.p_comm)
		else $error("primary reset set comm loss");
	// Reported level trails the synchroniser by one edge
	a_level_report: assert property (enable_pin_level == $past(state_reg.sync2[supervision_pkg::IX_EN])) // [RL5]
		else $error("enable level report wrong");

endmodule : enable_and_supervision
`default_nettype wire

// *** sec_chip_model.sv ***
`default_nettype none
// Behavioural secondary chip: sends lifesigns, watches ours, reports faults
module sec_chip_model (
	// Clock and reset
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	// Scenario controls
	input  wire logic                         stall,
	input  wire logic [2:0]                   fault_cmd,
	// Link toward the primary
	input  wire logic                         lifesign_tx,
	output logic                              lifesign_rx,
	output supervision_pkg::sec_status_s      sec_status
);
	timeunit 1ns;
	timeprecision 1ps;

	int per_cnt;
	int rx_cnt;

	////////////////////////////////////////////////////////////////
	// Pulse held 4 cycles so the two-flop sync never misses it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_cnt     <= 0;
			rx_cnt      <= 0;
			lifesign_rx <= 1'b0;
		end else begin
			per_cnt     <= (per_cnt == supervision_pkg::LS_PERIOD_CYC - 1) ? 0 : per_cnt + 1;
			lifesign_rx <= !stall && (per_cnt < 4);
			rx_cnt      <= lifesign_tx ? 0 : ((rx_cnt < supervision_pkg::LS_TIMEOUT_CYC) ? rx_cnt + 1 : rx_cnt);
		end
	end

	////////////////////////////////////////////////////////////////
	// Fault report: oscillator, hard fault, memory, lost primary lifesign
	assign sec_status = {fault_cmd, rx_cnt >= supervision_pkg::LS_TIMEOUT_CYC};
endmodule : sec_chip_model
`default_nettype wire

// *** tb_enable_and_supervision.sv ***
`default_nettype none
module tb_enable_and_supervision;
	timeunit 1ns;
	timeprecision 1ps;

	logic                          pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
	logic [7:0]                    paddr;
	logic [31:0]                   pwdata, prdata, rd;
	logic                          enable_pin, bias_ref_fault, primary_osc_fail, stall, lifesign_tx, lifesign_rx;
	logic                          reset_event, pwm_off, disabled, enable_pin_level, enable_valid_status;
	logic                          secondary_ready_status;
	logic [2:0]                    fault_cmd;
	supervision_pkg::notify_s      notify;
	supervision_pkg::sec_status_s  sec_status;
	int                            fails, checks, n;

	////////////////////////////////////////////////////////////////
	// 50 MHz clock
	initial pclk = 1'b0;
	always #10 pclk = ~pclk;

	enable_and_supervision dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.enable_pin(enable_pin), .lifesign_rx(lifesign_rx), .bias_ref_fault(bias_ref_fault),
		.primary_osc_fail(primary_osc_fail), .sec_status(sec_status), .notify(notify), .lifesign_tx(lifesign_tx),
		.reset_event(reset_event), .pwm_off(pwm_off), .disabled(disabled), .enable_pin_level(enable_pin_level),
		.enable_valid_status(enable_valid_status), .secondary_ready_status(secondary_ready_status));

	sec_chip_model partner (.pclk(pclk), .presetn(presetn), .stall(stall), .fault_cmd(fault_cmd),
		.lifesign_tx(lifesign_tx), .lifesign_rx(lifesign_rx), .sec_status(sec_status));

	////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic wrap_up;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", name, exp, got);
			fails++;
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc

	// One APB transfer; holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd       = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Let the write land before any caller looks at outputs
		@(posedge pclk);
		if (k >= 50) begin
			fails++;
			wrap_up();
		end
	endtask : apb

	// Pin change, then enough edges for sync and state update
	task automatic pin(input logic v);
		@(posedge pclk);
		enable_pin <= v;
		cyc(6);
	endtask : pin

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, enable_pin, bias_ref_fault, primary_osc_fail, stall} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		fault_cmd = 3'h0;
		fails = 0;
		checks = 0;
		cyc(4);
		presetn <= 1'b1;
		chk("notify", 32'h7, notify);
		chk("disabled", 32'h1, disabled);
		apb(1'b0, supervision_pkg::CFG_OFS, 32'h0);
		chk("cfg", 32'h0, rd);
		apb(1'b0, supervision_pkg::FLAGS_OFS, 32'h0);
		chk("flags", 32'h0, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("slverr", 32'h1, last_err);
		$display("test reset done");

		// Enable edges across modes; only 4->3 and 6->5 assert the line
		pin(1'b1);
		chk("en level", 32'h1, enable_pin_level);
		chk("en valid", 32'h1, enable_valid_status);
		apb(1'b0, supervision_pkg::STATUS_OFS, 32'h0);
		chk("status en", 32'h3, rd & 32'h3);
		apb(1'b1, supervision_pkg::CTRL_OFS, 32'h4);
		pin(1'b0);
		chk("fault_a_n", 32'h0, notify.fault_a_n);
		chk("en level", 32'h0, enable_pin_level);
		chk("en valid", 32'h0, enable_valid_status);
		chk("disabled", 32'h1, disabled);
		apb(1'b0, supervision_pkg::CTRL_OFS, 32'h0);
		chk("mode", 32'h3, rd & 32'h7);
		apb(1'b0, supervision_pkg::STATUS_OFS, 32'h0);
		chk("status en", 32'h0, rd & 32'h3);
		pin(1'b1);
		chk("fault_a_n", 32'h1, notify.fault_a_n);
		apb(1'b1, supervision_pkg::CTRL_OFS, 32'h6);
		pin(1'b0);
		chk("fault_a_n", 32'h0, notify.fault_a_n);
		apb(1'b0, supervision_pkg::CTRL_OFS, 32'h0);
		chk("mode", 32'h5, rd & 32'h7);
		apb(1'b1, supervision_pkg::CTRL_OFS, 32'h4);
		pin(1'b1);
		chk("fault_a_n", 32'h0, notify.fault_a_n);
		apb(1'b1, supervision_pkg::CTRL_OFS, 32'h8);
		chk("fault_a_n", 32'h1, notify.fault_a_n);
		pin(1'b0);
		chk("fault_a_n", 32'h1, notify.fault_a_n);
		apb(1'b0, supervision_pkg::FLAGS_OFS, 32'h0);
		chk("class a flag", 32'h8, rd & 32'h8);
		pin(1'b1);
		$display("test enable done");

		// Lifesign loss from the far side
		apb(1'b1, supervision_pkg::CTRL_OFS, 32'h18);
		stall <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (reset_event !== 1'b1 && n < 1800);
		chk("ls window", 32'h1, n >= 1000 && n < 1800);
		if (n >= 1800) begin
			wrap_up();
		end
		cyc(2);
		chk("fault_b_n", 32'h0, notify.fault_b_n);
		chk("ready", 32'h0, secondary_ready_status);
		apb(1'b0, supervision_pkg::FLAGS_OFS, 32'h0);
		chk("comm flags", 32'h3, rd & 32'h3);
		apb(1'b0, supervision_pkg::CTRL_OFS, 32'h0);
		chk("mode", 32'h0, rd & 32'h7);
		stall <= 1'b0;
		cyc(600);
		chk("ready", 32'h1, secondary_ready_status);
		apb(1'b1, supervision_pkg::CTRL_OFS, 32'h18);
		$display("test lifesign done");

		// Secondary failures: oscillator, hard fault, memory
		for (int i = 0; i < 3; i++) begin
			fault_cmd <= 3'h4 >> i;
			cyc(5);
			chk("ready", 32'h0, secondary_ready_status);
			chk("disabled", 32'h1, disabled);
			chk("pwm_off", 32'h1, pwm_off);
			chk("fault_b_n", 32'h0, notify.fault_b_n);
			apb(1'b0, supervision_pkg::FLAGS_OFS, 32'h0);
			chk("p comm", 32'h1, rd & 32'h1);
			fault_cmd <= 3'h0;
			cyc(5);
			apb(1'b1, supervision_pkg::CTRL_OFS, 32'h18);
			chk("fault_b_n", 32'h1, notify.fault_b_n);
		end
		$display("test secondary done");

		// Primary failures: bias pin and oscillator start
		for (int i = 0; i < 2; i++) begin
			bias_ref_fault   <= (i == 0);
			primary_osc_fail <= (i == 1);
			// Long bias fault lets the far side lose our lifesign
			cyc((i == 0) ? 1600 : 5);
			chk("reset_ready_n", 32'h0, notify.reset_ready_n);
			chk("pwm_off", 32'h1, pwm_off);
			bias_ref_fault   <= 1'b0;
			primary_osc_fail <= 1'b0;
			cyc(5);
			chk("reset_ready_n", 32'h1, notify.reset_ready_n);
			chk("fault_b_n", 32'h0, notify.fault_b_n);
			apb(1'b0, supervision_pkg::FLAGS_OFS, 32'h0);
			chk("flags", (i == 0) ? 32'h6 : 32'h4, rd & 32'h7);
			cyc(600);
			apb(1'b1, supervision_pkg::CTRL_OFS, 32'h18);
		end
		$display("test primary done");

		// Configuration parity error on the primary
		apb(1'b1, supervision_pkg::CFG_OFS, 32'hA5);
		apb(1'b0, supervision_pkg::CFG_OFS, 32'h0);
		chk("cfg", 32'hA5, rd);
		apb(1'b1, supervision_pkg::CTRL_OFS, 32'h20);
		cyc(5);
		chk("reset_ready_n", 32'h0, notify.reset_ready_n);
		chk("pwm_off", 32'h1, pwm_off);
		apb(1'b1, supervision_pkg::CTRL_OFS, 32'h0);
		cyc(5);
		chk("reset_ready_n", 32'h1, notify.reset_ready_n);
		chk("fault_b_n", 32'h0, notify.fault_b_n);
		apb(1'b0, supervision_pkg::CFG_OFS, 32'h0);
		chk("cfg", 32'h0, rd);
		$display("test memory done");
		wrap_up();
	end
endmodule : tb_enable_and_supervision
`default_nettype wire
